/* hw/cas_signaling_handler.v */
// Channel-associated signaling handler for one TDM port, both directions
//
// Functional notes
// (R1) Per bundle, packet signaling comes from serial input or software transmit table.
// (R2) Serial input signaling change sets per-timeslot flag; interrupt gated by mask.
// (R3) One software transmit table per port: four rows of eight nibbles.
// (R4) E1 ports ignore transmit entries of timeslots 0 and 16.
// (R5) T1 ports ignore transmit entries of timeslots 24 to 31.
// (R6) Superframe nibbles hold A,B,A,B; others hold A,B,C,D.
// (R7) Timeslot k nibble sits at bits 4*(k mod 8)+3:4*(k mod 8), A on top.
// (R8) Matching framing passes bits as-is; ESF into SF keeps only A and B.
// (R9) SF into ESF keeps A and B, fills C and D from port field.
// (R10) Per-bundle destination framing bit steers T1 conversion.
// (R11) Receive multiframe sync free-runs internally, resynced to incoming pulses.
// (R12) Received payload signaling is written into SDRAM jitter buffers, 128 slots.
// (R13) Unassigned or unstructured timeslots take signaling from software receive table.
// (R14) Underrun with receive-source bit 1 takes software receive table.
// (R15) Structured timeslots take jitter buffer; underrun with bit 0 repeats latest value.
// (R16) At each transmit multiframe boundary next-multiframe table copies into line table.
// (R17) Line values refresh once per multiframe: 2, 1.5 or 3 milliseconds.
// (R18) Line table has 32 rows; T1 uses only the first 24.
// (R19) Line rows hold A,B,C,D, or A,B,A,B on superframe ports.
// (R20) Any line table change sets that timeslot's receive-change flag and interrupt.
// (R21) Line table is shifted out serially in timeslot order.
// (R22) Transmit multiframe free-runs internally, resynced to transmit frame sync and multiframe marker pulses.
// (R23) Framer using software signaling takes it from its registers, not its pin.
// (R24) Framer presents signaling serially, aligned to its timeslot, order A,B,C,D.
`timescale 1ns/10ps
`default_nettype none
`include "cas_signaling_handler_regs.vh"
module cas_signaling_handler
#(
  parameter [6:0] SDRAM_BASE = 7'h00
)
(
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_b,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [31:0] reg_rdata,
  // TDM signaling pins
  input  wire        rx_tdm_clock,
  input  wire        rx_signaling_serial_in,
  input  wire        rx_multiframe_sync,
  input  wire        tx_frame_sync,
  input  wire        tx_multiframe_marker,
  output wire        tx_signaling_serial_out,
  // Packet transmit side: signaling for insertion
  input  wire        pkt_tx_req,
  input  wire [4:0]  pkt_tx_ts,
  output wire        pkt_tx_valid,
  output wire [3:0]  pkt_tx_cas,
  // Packet receive side: extracted signaling
  input  wire        pkt_rx_wr,
  input  wire [4:0]  pkt_rx_ts,
  input  wire [3:0]  pkt_rx_cas,
  input  wire [3:0]  jb_underrun,
  // SDRAM jitter buffer write
  output wire        sdram_cas_we,
  output wire [6:0]  sdram_cas_addr,
  output wire [3:0]  sdram_cas_data,
  // Change indications
  output wire        tx_cas_change_irq,
  output wire        rx_cas_change_irq
);

  localparam integer E1_MF_FRAMES  = (`E1_MF_US / `FRAME_US);
  localparam integer SF_MF_FRAMES  = (`SF_MF_US / `FRAME_US);
  localparam integer ESF_MF_FRAMES = (`ESF_MF_US / `FRAME_US);

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  function [3:0] get_nib;
    input [127:0] vec;
    input [4:0]   ts;
    begin
      get_nib = vec[{ts, 2'b00} +: 4];
    end
  endfunction

  function ts_used;
    input [4:0] ts;
    input [1:0] frm;
    begin
      if (frm == `FRM_E1)
        ts_used = (ts != 5'h00) && (ts != 5'h10); // R4
      else
        ts_used = (ts < 5'h18); // R5
    end
  endfunction

  // Timeslot and bit from frame position; T1 frames open with the F bit
  function [8:0] slot_of;
    input [8:0] pos;
    input [1:0] frm;
    reg   [8:0] p;
    begin
      p = (frm == `FRM_E1) ? pos : pos - 9'h001;
      if ((frm != `FRM_E1) && (pos == 9'h000))
        slot_of = 9'h1FF;
      else
        slot_of = {1'b0, p[7:3], p[2:0]};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bit tick

  reg  [4:0]  sync_a_ff;
  reg  [4:0]  sync_b_ff;
  reg         clk_prev_ff;
  wire        tick;

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_a_ff   <= 5'h00;
      sync_b_ff   <= 5'h00;
      clk_prev_ff <= 1'b0;
    end
    else
    begin
      sync_a_ff   <= {tx_multiframe_marker, tx_frame_sync, rx_multiframe_sync,
                      rx_signaling_serial_in, rx_tdm_clock};
      sync_b_ff   <= sync_a_ff;
      clk_prev_ff <= sync_b_ff[0];
    end
  end

  // Rising edge of the line clock; data and syncs sampled there
  assign tick = sync_b_ff[0] & ~clk_prev_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  reg  [31:0]  ctrl_ff;
  reg  [31:0]  bundle_cfg_ff;
  reg  [31:0]  rx_assign_ff;
  reg  [63:0]  ts_map_ff;
  reg  [31:0]  tx_chg_mask_ff;
  reg  [127:0] tx_soft_ff;
  reg  [127:0] rx_soft_ff;
  wire [1:0]   framing;
  wire [1:0]   fill_cd;
  wire [8:0]   frame_bits;
  reg  [4:0]   mf_frames;
  wire [1:0]   row;

  assign framing    = ctrl_ff[`CTRL_FRM_LSB +: 2];
  assign fill_cd    = ctrl_ff[`CTRL_FILL_LSB +: 2];
  assign frame_bits = (framing == `FRM_E1) ? `E1_FRAME_BITS : `T1_FRAME_BITS;
  assign row        = reg_addr[3:2];

  // Multiframe length sets the line refresh period
  always @*
  begin
    case (framing)
      `FRM_E1:  mf_frames = E1_MF_FRAMES[4:0]; // R17
      `FRM_SF:  mf_frames = SF_MF_FRAMES[4:0]; // R17
      `FRM_ESF: mf_frames = ESF_MF_FRAMES[4:0]; // R17
      default:  mf_frames = E1_MF_FRAMES[4:0];
    endcase
  end

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_ff        <= `CTRL_RESET;
      bundle_cfg_ff  <= `BUNDLE_CFG_RESET;
      rx_assign_ff   <= 32'h00000000;
      ts_map_ff      <= 64'h0000000000000000;
      tx_chg_mask_ff <= 32'h00000000;
      tx_soft_ff     <= 128'h0;
      rx_soft_ff     <= 128'h0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `REG_CTRL:           ctrl_ff          <= {28'h0000000, reg_wdata[3:0]};
        `REG_BUNDLE_CFG:     bundle_cfg_ff    <= {16'h0000, reg_wdata[15:0]};
        `REG_RX_ASSIGN:      rx_assign_ff     <= reg_wdata;
        `REG_TS_MAP_LO:      ts_map_ff[31:0]  <= reg_wdata;
        `REG_TS_MAP_HI:      ts_map_ff[63:32] <= reg_wdata;
        `REG_TX_CHANGE_MASK: tx_chg_mask_ff   <= reg_wdata;
        default:
        begin
          if (reg_addr[7:4] == `GRP_TX_SOFT)
            tx_soft_ff[{row, 5'h00} +: 32] <= reg_wdata; // R3
          if (reg_addr[7:4] == `GRP_RX_SOFT)
            rx_soft_ff[{row, 5'h00} +: 32] <= reg_wdata;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive-side framing and serial capture

  wire [8:0]   rx_pos;
  wire         rx_mf_start;
  wire [8:0]   rx_slot;
  reg  [2:0]   rx_shift_ff;
  reg  [127:0] captured_ff;
  reg  [31:0]  tx_chg_ff;
  reg  [31:0]  tx_chg_set;
  wire [3:0]   rx_nib;

  mf_sync_gen u_rx_sync
  (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .tick        (tick),
    .frame_bits  (frame_bits),
    .mf_frames   (mf_frames),
    .frame_pulse (1'b0),
    .mf_pulse    (sync_b_ff[2]), // R11
    .bit_pos     (rx_pos),
    .frame_idx   (),
    .mf_start    (rx_mf_start)
  );

  assign rx_slot = slot_of(rx_pos, framing);
  assign rx_nib  = {rx_shift_ff, sync_b_ff[1]};

  always @*
  begin
    tx_chg_set = 32'h00000000;
    if (tick && (rx_slot[2:0] == 3'h3) && !rx_slot[8] && ts_used(rx_slot[7:3], framing)
        && (get_nib(captured_ff, rx_slot[7:3]) != rx_nib))
      tx_chg_set[rx_slot[7:3]] = 1'b1; // R2
  end

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_shift_ff <= 3'h0;
      captured_ff <= 128'h0;
      tx_chg_ff   <= 32'h00000000;
    end
    else
    begin
      if (tick && !rx_slot[8] && (rx_slot[2:0] < 3'h4))
        rx_shift_ff <= rx_nib[2:0]; // R24
      if (tick && !rx_slot[8] && (rx_slot[2:0] == 3'h3))
        captured_ff[{rx_slot[7:3], 2'b00} +: 4] <= rx_nib; // R7
      // Set wins over a clear in the same cycle
      tx_chg_ff <= (tx_chg_ff & ~((reg_wr && reg_addr == `REG_TX_CHANGE) ? reg_wdata : 32'h0))
                   | tx_chg_set; // R2
    end
  end

  assign tx_cas_change_irq = |(tx_chg_ff & ~tx_chg_mask_ff); // R2

  //////////////////////////////////////////////////////////////////////////////
  // Transmit-direction insertion into packets

  reg         pkt_tx_valid_ff;
  reg  [3:0]  pkt_tx_cas_ff;
  wire [1:0]  tx_bundle;
  wire [3:0]  tx_bcfg;
  wire [3:0]  tx_raw;
  reg  [3:0]  tx_conv;

  assign tx_bundle = ts_map_ff[{pkt_tx_ts, 1'b0} +: 2];
  assign tx_bcfg   = bundle_cfg_ff[{tx_bundle, 2'b00} +: 4];
  assign tx_raw    = tx_bcfg[`BCFG_TX_SRC] ? get_nib(tx_soft_ff, pkt_tx_ts)
                                           : get_nib(captured_ff, pkt_tx_ts); // R1

  always @*
  begin
    tx_conv = tx_raw; // R8
    if ((framing == `FRM_SF) && tx_bcfg[`BCFG_DST_ESF]) // R10
      tx_conv = {tx_raw[3:2], fill_cd}; // R9
    else if ((framing == `FRM_ESF) && !tx_bcfg[`BCFG_DST_ESF]) // R10
      tx_conv = {tx_raw[3:2], tx_raw[3:2]}; // R8
    if (!ts_used(pkt_tx_ts, framing))
      tx_conv = 4'h0; // R4 R5
  end

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pkt_tx_valid_ff <= 1'b0;
      pkt_tx_cas_ff   <= 4'h0;
    end
    else
    begin
      pkt_tx_valid_ff <= pkt_tx_req;
      if (pkt_tx_req)
        pkt_tx_cas_ff <= tx_conv; // R6
    end
  end

  assign pkt_tx_valid = pkt_tx_valid_ff;
  assign pkt_tx_cas   = pkt_tx_cas_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Receive-direction jitter buffer write and source selection

  reg          sdram_we_ff;
  reg  [6:0]   sdram_addr_ff;
  reg  [3:0]   sdram_data_ff;
  reg  [127:0] latest_ff;
  reg  [127:0] next_mf_ff;
  reg  [4:0]   scan_ff;
  wire [1:0]   sc_bundle;
  wire [3:0]   sc_bcfg;
  wire         sc_soft;

  assign sc_bundle = ts_map_ff[{scan_ff, 1'b0} +: 2];
  assign sc_bcfg   = bundle_cfg_ff[{sc_bundle, 2'b00} +: 4];
  assign sc_soft   = !rx_assign_ff[scan_ff] || !sc_bcfg[`BCFG_STRUCT] // R13
                     || (jb_underrun[sc_bundle] && sc_bcfg[`BCFG_RX_SRC]); // R14

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sdram_we_ff   <= 1'b0;
      sdram_addr_ff <= 7'h00;
      sdram_data_ff <= 4'h0;
      latest_ff     <= 128'h0;
      next_mf_ff    <= 128'h0;
      scan_ff       <= 5'h00;
    end
    else
    begin
      sdram_we_ff <= pkt_rx_wr;
      if (pkt_rx_wr)
      begin
        sdram_addr_ff <= SDRAM_BASE + {2'b00, pkt_rx_ts}; // R12
        sdram_data_ff <= pkt_rx_cas; // R12
        latest_ff[{pkt_rx_ts, 2'b00} +: 4] <= pkt_rx_cas;
      end
      // Underrun with source bit 0 keeps the last value in place
      next_mf_ff[{scan_ff, 2'b00} +: 4] <= sc_soft ? get_nib(rx_soft_ff, scan_ff)
                                                   : get_nib(latest_ff, scan_ff); // R15
      scan_ff <= scan_ff + 5'h01;
    end
  end

  assign sdram_cas_we   = sdram_we_ff;
  assign sdram_cas_addr = sdram_addr_ff;
  assign sdram_cas_data = sdram_data_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Transmit framing, line table and serial output

  wire [8:0]   tx_pos;
  wire         tx_mf_start;
  wire [8:0]   tx_slot;
  reg  [127:0] line_ff;
  reg  [31:0]  rx_chg_ff;
  reg  [31:0]  rx_chg_set;
  reg          tsig_ff;
  integer      i;

  mf_sync_gen u_tx_sync
  (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .tick        (tick),
    .frame_bits  (frame_bits),
    .mf_frames   (mf_frames),
    .frame_pulse (sync_b_ff[3]), // R22
    .mf_pulse    (sync_b_ff[4]),
    .bit_pos     (tx_pos),
    .frame_idx   (),
    .mf_start    (tx_mf_start)
  );

  assign tx_slot = slot_of(tx_pos, framing);

  always @*
  begin
    rx_chg_set = 32'h00000000;
    for (i = 0; i < 32; i = i + 1)
      if (tx_mf_start && (line_ff[4*i +: 4] != next_mf_ff[4*i +: 4]))
        rx_chg_set[i] = 1'b1; // R20
  end

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      line_ff   <= 128'h0;
      rx_chg_ff <= 32'h00000000;
      tsig_ff   <= 1'b0;
    end
    else
    begin
      if (tx_mf_start)
        line_ff <= next_mf_ff; // R16 R19
      rx_chg_ff <= (rx_chg_ff & ~((reg_wr && reg_addr == `REG_RX_CHANGE) ? reg_wdata : 32'h0))
                   | rx_chg_set; // R20
      if (tick)
      begin
        if (!tx_slot[8] && (tx_slot[2:0] < 3'h4) && ts_used(tx_slot[7:3], framing)) // R18
          tsig_ff <= line_ff[{tx_slot[7:3], 2'b00} + 7'h3 - {4'h0, tx_slot[2:0]}]; // R21
        else
          tsig_ff <= 1'b0;
      end
    end
  end

  assign tx_signaling_serial_out = tsig_ff;
  assign rx_cas_change_irq       = |rx_chg_ff; // R20

  //////////////////////////////////////////////////////////////////////////////
  // Register read-back, one cycle after the strobe

  reg  [31:0] rdata_ff;
  reg  [31:0] rd_mux;

  always @*
  begin
    case (reg_addr)
      `REG_CTRL:           rd_mux = ctrl_ff;
      `REG_BUNDLE_CFG:     rd_mux = bundle_cfg_ff;
      `REG_RX_ASSIGN:      rd_mux = rx_assign_ff;
      `REG_TS_MAP_LO:      rd_mux = ts_map_ff[31:0];
      `REG_TS_MAP_HI:      rd_mux = ts_map_ff[63:32];
      `REG_TX_CHANGE:      rd_mux = tx_chg_ff;
      `REG_TX_CHANGE_MASK: rd_mux = tx_chg_mask_ff;
      `REG_RX_CHANGE:      rd_mux = rx_chg_ff;
      default:
      begin
        case (reg_addr[7:4])
          `GRP_TX_SOFT:  rd_mux = tx_soft_ff[{row, 5'h00} +: 32];
          `GRP_RX_SOFT:  rd_mux = rx_soft_ff[{row, 5'h00} +: 32];
          `GRP_LINE:     rd_mux = line_ff[{row, 5'h00} +: 32];
          `GRP_NEXT_MF:  rd_mux = next_mf_ff[{row, 5'h00} +: 32];
          `GRP_CAPTURED: rd_mux = captured_ff[{row, 5'h00} +: 32];
          default:       rd_mux = 32'h00000000;
        endcase
        if (reg_addr[1:0] != 2'b00)
          rd_mux = 32'h00000000;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_ff <= 32'h00000000;
    else
      rdata_ff <= reg_rd ? rd_mux : 32'h00000000;
  end

  assign reg_rdata = rdata_ff;

endmodule
`default_nettype wire

/* hw/cas_signaling_handler_regs.vh */
// Register offsets, field positions, reset values and timing constants of the signaling handler
`ifndef CAS_SIGNALING_HANDLER_REGS_VH
`define CAS_SIGNALING_HANDLER_REGS_VH

// Register offsets (byte addresses, one 32-bit word each)
`define REG_CTRL           8'h00
`define REG_BUNDLE_CFG     8'h04
`define REG_RX_ASSIGN      8'h08
`define REG_TS_MAP_LO      8'h0C
`define REG_TS_MAP_HI      8'h10
`define REG_TX_CHANGE      8'h14
`define REG_TX_CHANGE_MASK 8'h18
`define REG_RX_CHANGE      8'h1C
// Table groups, four rows each, selected by address bits 7:4
`define GRP_TX_SOFT        4'h2
`define GRP_RX_SOFT        4'h3
`define GRP_LINE           4'h4
`define GRP_NEXT_MF        4'h5
`define GRP_CAPTURED       4'h6

// Control register fields
`define CTRL_FRM_LSB       0
`define CTRL_FILL_LSB      2
`define CTRL_RESET         32'h00000000

// Framing codes
`define FRM_E1             2'h0
`define FRM_SF             2'h1
`define FRM_ESF            2'h2

// Per-bundle nibble of the bundle configuration register
`define BCFG_TX_SRC        0
`define BCFG_DST_ESF       1
`define BCFG_RX_SRC        2
`define BCFG_STRUCT        3
`define BUNDLE_CFG_RESET   32'h00000000

// Frame and multiframe timing
`define FRAME_US           125
`define E1_MF_US           2000
`define SF_MF_US           1500
`define ESF_MF_US          3000
`define E1_FRAME_BITS      9'h100
`define T1_FRAME_BITS      9'h0C1

`endif

/* hw/mf_sync_gen.v */
// Free-running frame and multiframe counter with resync to external pulses
`timescale 1ns/10ps
`default_nettype none
module mf_sync_gen
(
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst_b,
  // Bit timing
  input  wire       tick,
  input  wire [8:0] frame_bits,
  input  wire [4:0] mf_frames,
  // External sync, sampled with tick
  input  wire       frame_pulse,
  input  wire       mf_pulse,
  // Position of the bit taken at this tick
  output wire [8:0] bit_pos,
  output wire [4:0] frame_idx,
  output wire       mf_start
);

  reg  [8:0] bit_ff;
  reg  [4:0] frm_ff;
  wire [8:0] cur_bit;
  wire [4:0] cur_frm;

  // A pulse marks the current bit as the first of its frame or multiframe
  assign cur_bit   = (frame_pulse | mf_pulse) ? 9'h000 : bit_ff;
  assign cur_frm   = mf_pulse ? 5'h00 : frm_ff;
  assign bit_pos   = cur_bit;
  assign frame_idx = cur_frm;
  assign mf_start  = tick & (cur_bit == 9'h000) & (cur_frm == 5'h00);

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bit_ff <= 9'h000;
      frm_ff <= 5'h00;
    end
    else if (tick)
    begin
      if (cur_bit == frame_bits - 9'h001)
      begin
        bit_ff <= 9'h000;
        frm_ff <= (cur_frm == mf_frames - 5'h01) ? 5'h00 : cur_frm + 5'h01;
      end
      else
      begin
        bit_ff <= cur_bit + 9'h001;
        frm_ff <= cur_frm;
      end
    end
  end

endmodule
`default_nettype wire

/* test/cas_signaling_handler_chk.sv */
// Port-level assertions for the signaling handler
`timescale 1ns/10ps
`default_nettype none
module cas_signaling_handler_chk
#(
  parameter [6:0] SDRAM_BASE = 7'h00
)
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // Register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Line side
  input wire logic        rx_tdm_clock,
  input wire logic        tx_multiframe_marker,
  input wire logic        tx_signaling_serial_out,
  // Packet sides
  input wire logic        pkt_tx_req,
  input wire logic        pkt_tx_valid,
  input wire logic [3:0]  pkt_tx_cas,
  input wire logic        pkt_rx_wr,
  input wire logic [4:0]  pkt_rx_ts,
  input wire logic [3:0]  pkt_rx_cas,
  input wire logic        sdram_cas_we,
  input wire logic [6:0]  sdram_cas_addr,
  input wire logic [3:0]  sdram_cas_data,
  // Change indications
  input wire logic        tx_cas_change_irq,
  input wire logic        rx_cas_change_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_rx_taken;
    pkt_rx_wr;
  endsequence
  sequence s_we_out;
    sdram_cas_we ##0 sdram_cas_data == $past(pkt_rx_cas);
  endsequence
  AST_SDRAM_WE: assert property (s_rx_taken |=> s_we_out)
    else $error("jitter buffer write missing or wrong data");
  AST_SDRAM_ADDR: assert property (pkt_rx_wr |=> sdram_cas_addr == SDRAM_BASE + {2'h0, $past(pkt_rx_ts)})
    else $error("jitter buffer address wrong");
  AST_WE_CAUSE: assert property (sdram_cas_we |-> $past(pkt_rx_wr))
    else $error("jitter buffer write without cause");
  AST_TX_VALID: assert property (pkt_tx_req |=> pkt_tx_valid)
    else $error("signaling answer missing");
  AST_VALID_CAUSE: assert property (pkt_tx_valid |-> $past(pkt_tx_req))
    else $error("signaling answer without request");
  AST_CAS_HOLD: assert property (!$past(pkt_tx_req) |-> $stable(pkt_tx_cas))
    else $error("signaling nibble changed without request");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
    else $error("read data outside read slot");
  AST_TX_IRQ_RISE: assert property ($rose(tx_cas_change_irq) |-> rx_tdm_clock || $past(reg_wr))
    else $error("transmit change interrupt off a bit tick");
  AST_IRQ_FALL: assert property ($fell(tx_cas_change_irq) || $fell(rx_cas_change_irq) |-> $past(reg_wr))
    else $error("change interrupt dropped without register write");
  AST_RX_IRQ_RISE: assert property ($rose(rx_cas_change_irq) |-> tx_multiframe_marker)
    else $error("line change interrupt off multiframe boundary");
  AST_OUT_TICK: assert property ($changed(tx_signaling_serial_out) |-> $past(rx_tdm_clock))
    else $error("serial signaling changed off a bit tick");
endmodule
bind cas_signaling_handler cas_signaling_handler_chk #(.SDRAM_BASE(SDRAM_BASE)) u_chk
(
  .core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_tdm_clock(rx_tdm_clock), .tx_multiframe_marker(tx_multiframe_marker),
  .tx_signaling_serial_out(tx_signaling_serial_out), .pkt_tx_req(pkt_tx_req), .pkt_tx_valid(pkt_tx_valid),
  .pkt_tx_cas(pkt_tx_cas), .pkt_rx_wr(pkt_rx_wr), .pkt_rx_ts(pkt_rx_ts), .pkt_rx_cas(pkt_rx_cas),
  .sdram_cas_we(sdram_cas_we), .sdram_cas_addr(sdram_cas_addr), .sdram_cas_data(sdram_cas_data),
  .tx_cas_change_irq(tx_cas_change_irq), .rx_cas_change_irq(rx_cas_change_irq)
);
`default_nettype wire

/* test/tdm_framer_model.sv */
// Behavioural E1 framer driving and sampling the signaling lines
`timescale 1ns/10ps
`default_nettype none
module tdm_framer_model
(
  // Line timing
  output logic              link_clk,
  output logic              frame_sync,
  output logic              mf_marker,
  // Signaling lines
  output logic              sig_serial,
  input  wire logic         sig_return,
  input  wire logic [127:0] nib_tab
);
  logic [7:0]   pos;
  logic [3:0]   frm;
  logic [255:0] seen_bits;
  initial
  begin
    pos = 8'hFF;
    frm = 4'hF;
    frame_sync = 1'b0;
    mf_marker = 1'b0;
    sig_serial = 1'b0;
    seen_bits = '0;
    link_clk = 1'b0;
    forever #40 link_clk = ~link_clk;
  end
  // Next bit presented half a period before the sampling edge
  always @(negedge link_clk)
  begin
    seen_bits[pos] = sig_return;
    if (pos == 8'hFF)
      frm = frm + 4'h1;
    pos = pos + 8'h01;
    frame_sync = (pos == 8'h00);
    mf_marker = (pos == 8'h00) && (frm == 4'h0);
    if (pos[2] == 1'b0)
      sig_serial = nib_tab[{pos[7:3], 2'h3} - {5'h00, pos[1:0]}];
    else
      sig_serial = pos[0] ^ frm[0];
  end
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the signaling handler
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {logic [3:0] ctrl; logic [3:0] bcfg; logic [4:0] ts; logic [3:0] cas;} row_t;
  logic         core_clk;
  logic         rst_b;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  wire  [31:0]  reg_rdata;
  wire          lclk, rsig, fsync, mfm, tsig, tx_irq, rx_irq;
  logic         pkt_tx_req;
  logic [4:0]   pkt_tx_ts;
  wire          pkt_tx_valid;
  wire  [3:0]   pkt_tx_cas;
  logic         pkt_rx_wr;
  logic [4:0]   pkt_rx_ts;
  logic [3:0]   pkt_rx_cas;
  logic [3:0]   jb_underrun;
  wire          sdram_cas_we;
  wire  [6:0]   sdram_cas_addr;
  wire  [3:0]   sdram_cas_data;
  logic [127:0] nib_tab;
  logic [255:0] sb;
  int           n_fail;
  int           checks;
  row_t         rows [10] = '{'{4'h0, 4'h1, 5'h01, 4'hB}, '{4'h0, 4'h1, 5'h00, 4'h0},
    '{4'h0, 4'h1, 5'h10, 4'h0}, '{4'h0, 4'h1, 5'h11, 4'h3}, '{4'h0, 4'h1, 5'h1F, 4'h1},
    '{4'hD, 4'h3, 5'h07, 4'hF}, '{4'hD, 4'h3, 5'h18, 4'h0}, '{4'h2, 4'h1, 5'h02, 4'h0},
    '{4'h2, 4'h3, 5'h03, 4'hC}, '{4'h1, 4'h1, 5'h05, 4'hD}};
  cas_signaling_handler #(.SDRAM_BASE(7'h20)) dut
  (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_tdm_clock(lclk), .rx_signaling_serial_in(rsig), .rx_multiframe_sync(mfm),
    .tx_frame_sync(fsync), .tx_multiframe_marker(mfm), .tx_signaling_serial_out(tsig),
    .pkt_tx_req(pkt_tx_req), .pkt_tx_ts(pkt_tx_ts), .pkt_tx_valid(pkt_tx_valid), .pkt_tx_cas(pkt_tx_cas),
    .pkt_rx_wr(pkt_rx_wr), .pkt_rx_ts(pkt_rx_ts), .pkt_rx_cas(pkt_rx_cas), .jb_underrun(jb_underrun),
    .sdram_cas_we(sdram_cas_we), .sdram_cas_addr(sdram_cas_addr), .sdram_cas_data(sdram_cas_data),
    .tx_cas_change_irq(tx_irq), .rx_cas_change_irq(rx_irq)
  );
  tdm_framer_model u_model
  (
    .link_clk(lclk), .frame_sync(fsync), .mf_marker(mfm),
    .sig_serial(rsig), .sig_return(tsig), .nib_tab(nib_tab)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, $sformatf("register %h", a));
  endtask
  task automatic ptx(input logic [4:0] t, input logic [3:0] exp);
    @(posedge core_clk);
    pkt_tx_req <= 1'b1;
    pkt_tx_ts <= t;
    @(posedge core_clk);
    pkt_tx_req <= 1'b0;
    #1;
    chk(32'(pkt_tx_valid), 32'h1, "tx valid");
    chk(32'(pkt_tx_cas), 32'(exp), $sformatf("tx nibble ts %0d", t));
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Whole run needs about 370 us of line time
  initial
  begin
    #400000;
    n_fail++;
    test_done;
  end
  initial
  begin
    {rst_b, reg_wr, reg_rd, pkt_tx_req, pkt_rx_wr} = 5'h00;
    {reg_addr, reg_wdata, pkt_tx_ts, pkt_rx_ts, pkt_rx_cas, jb_underrun} = '0;
    nib_tab = '0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    rdc(8'h00, 32'h00000000);
    wr(8'h24, 32'h5A5A5A5A);
    rdc(8'h24, 32'h5A5A5A5A);
    wr(8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'h00000000);
    rdc(8'h84, 32'h00000000);
    $display("test registers done");
    wr(8'h20, 32'hE5D3C3BA);
    wr(8'h28, 32'h9876543F);
    wr(8'h2C, 32'h1234567C);
    foreach (rows[i])
    begin
      wr(8'h00, {28'h0000000, rows[i].ctrl});
      wr(8'h04, {28'h0000000, rows[i].bcfg});
      ptx(rows[i].ts, rows[i].cas);
    end
    $display("test software table and conversion done");
    wr(8'h00, 32'h00000000);
    wr(8'h04, 32'h00000000);
    repeat (8192) @(posedge core_clk);
    wr(8'h14, 32'hFFFFFFFF);
    @(posedge core_clk);
    nib_tab[23:20] <= 4'h9;
    nib_tab[3:0] <= 4'h6;
    nib_tab[67:64] <= 4'h7;
    repeat (8192) @(posedge core_clk);
    rdc(8'h14, 32'h00000020);
    chk(32'(tx_irq), 32'h1, "tx change irq");
    rdc(8'h60, 32'h00900006);
    ptx(5'h05, 4'h9);
    wr(8'h18, 32'h00000020);
    chk(32'(tx_irq), 32'h0, "masked tx irq");
    wr(8'h14, 32'h00000020);
    rdc(8'h14, 32'h00000000);
    wr(8'h18, 32'h00000000);
    $display("test serial input done");
    wr(8'h08, 32'h00000008);
    wr(8'h30, 32'h05000000);
    wr(8'h04, 32'h00000008);
    @(posedge core_clk);
    pkt_rx_wr <= 1'b1;
    pkt_rx_ts <= 5'h03;
    pkt_rx_cas <= 4'h9;
    @(posedge core_clk);
    pkt_rx_wr <= 1'b0;
    #1;
    chk(32'(sdram_cas_we), 32'h1, "sdram write");
    chk(32'({sdram_cas_addr, sdram_cas_data}), 32'h239, "sdram address and data");
    repeat (40) @(posedge core_clk);
    rdc(8'h50, 32'h05009000);
    jb_underrun <= 4'h1;
    wr(8'h04, 32'h0000000C);
    repeat (40) @(posedge core_clk);
    rdc(8'h50, 32'h05000000);
    wr(8'h04, 32'h00000008);
    repeat (40) @(posedge core_clk);
    rdc(8'h50, 32'h05009000);
    jb_underrun <= 4'h0;
    $display("test receive selection done");
    @(posedge mfm);
    wait (u_model.frm == 4'h2);
    sb = u_model.seen_bits;
    rdc(8'h40, 32'h05009000);
    rdc(8'h1C, 32'h00000048);
    chk(32'(rx_irq), 32'h1, "rx change irq");
    chk(32'({sb[24], sb[25], sb[26], sb[27]}), 32'h9, "line bits ts 3");
    chk(32'({sb[48], sb[49], sb[50], sb[51]}), 32'h5, "line bits ts 6");
    chk(32'({sb[0], sb[1], sb[2], sb[3]}), 32'h0, "line bits ts 0");
    wr(8'h1C, 32'h00000048);
    chk(32'(rx_irq), 32'h0, "cleared rx irq");
    $display("test multiframe copy done");
    test_done;
  end
endmodule
`default_nettype wire
